// file: src/rfb_cfg.svh
// Constants for the registered fanout buffer: widths and receiver timing.
// Assumes the core clock runs at the period given below.
`ifndef RFB_CFG_SVH
`define RFB_CFG_SVH

// ----------------------------------------------------------------------
// Widths
// ----------------------------------------------------------------------
`define RFB_DATA_W          13
`define RFB_SYNC_STAGES     3

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define RFB_CLK_PERIOD_NS   20
`define RFB_RX_ENABLE_NS    22
`define RFB_RX_DISABLE_NS   22
// A longest time rounds down, never below one cycle.
`define RFB_RX_ENABLE_CYC   (((`RFB_RX_ENABLE_NS) / (`RFB_CLK_PERIOD_NS)) < 1 ? 1 : \
                             ((`RFB_RX_ENABLE_NS) / (`RFB_CLK_PERIOD_NS)))
`define RFB_RX_STATE_RESET  2'h0

`endif

// file: src/rfb_pkg.sv
// Types shared by the registered fanout buffer.
// Assumes rfb_cfg.svh is on the include path.
`include "rfb_cfg.svh"

package rfb_pkg;

  // Receiver power state, Gray coded along off, wake, on.
  typedef enum logic [1:0]
  {
    RFB_RX_OFF  = 2'h0,
    RFB_RX_WAKE = 2'h1,
    RFB_RX_ON   = 2'h3
  } rfb_rx_state_t;

  // One sample of the differential pins.
  typedef struct packed
  {
    logic                     clk_true;
    logic                     clk_comp;
    logic [`RFB_DATA_W-1:0]   data;
  } rfb_pins_t;

endpackage

// file: src/rfb_buffer.sv
// Registered fanout buffer: 13 sampled inputs drive two identical banks.
// Assumes the differential pins arrive unsynchronised to clock_in, which
// must run well above the pin clock so that every crossing is seen.
`timescale 1ns/1ns
`include "rfb_cfg.svh"

// How it works
// - Two 13-bit registers, loaded from one word, drive two identical output banks, 26 outputs.
// - Capture data when true clock rises and complement falls, reset released.
// - Asserted pin reset clears the register and forces outputs low at once.
// - Receivers are off during reset; floating inputs cannot disturb outputs.
// - Pin reset acts asynchronously, independent of any clock edge.
// - Register is live at release; receivers wake up to 22 ns later.
module rfb_buffer
#(
  parameter int DATA_W     = `RFB_DATA_W,
  parameter int RX_EN_CYC  = `RFB_RX_ENABLE_CYC
)
(
  input  wire logic              clock_in,
  input  wire logic              sys_rst_in,
  input  wire logic              buf_rst_n_in,
  input  wire logic              clk_true_in,
  input  wire logic              clk_comp_in,
  input  wire logic [DATA_W-1:0] data_in,
  output logic      [DATA_W-1:0] out_bank_a_out,
  output logic      [DATA_W-1:0] out_bank_b_out,
  output logic                   rx_active_out
);

  // --------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------
  rfb_pkg::rfb_pins_t     sync1_ff;
  rfb_pkg::rfb_pins_t     sync2_ff;
  rfb_pkg::rfb_pins_t     sync3_ff;
  rfb_pkg::rfb_pins_t     lvl_ff;
  rfb_pkg::rfb_pins_t     raw_pins;
  rfb_pkg::rfb_pins_t     nxt_lvl;
  rfb_pkg::rfb_rx_state_t rx_state_ff;
  logic [7:0]             wake_cnt_ff;
  logic                   cross_lvl_ff;
  logic                   cross_now;
  logic [DATA_W-1:0]      out_bank_a_ff;
  logic [DATA_W-1:0]      out_bank_b_ff;
  logic                   rx_on;
  logic                   pin_rst;
  logic                   rx_active_ff;
  logic [DATA_W-1:0]      nxt_out_bank_a;
  logic [DATA_W-1:0]      nxt_out_bank_b;

  assign pin_rst        = ~buf_rst_n_in;
  assign rx_on          = rx_active_ff;
  assign out_bank_a_out = out_bank_a_ff;
  assign out_bank_b_out = out_bank_b_ff;
  assign rx_active_out  = rx_active_ff;

  // --------------------------------------------------------------------
  // Receiver power sequencing
  // --------------------------------------------------------------------
  // The register is live the moment the pin releases; the receivers wake
  // only after the wake count, so data sampled in between is ignored.
  always_ff @(posedge clock_in or posedge sys_rst_in or posedge pin_rst)
  begin
    if (sys_rst_in || pin_rst)
    begin
      rx_state_ff  <= rfb_pkg::RFB_RX_OFF;
      rx_active_ff <= 1'b0;
      wake_cnt_ff  <= 8'h00;
    end
    else
    begin
      case (rx_state_ff)
        rfb_pkg::RFB_RX_OFF:
        begin
          // The first edge after release already counts toward the wake time,
          // otherwise the receivers would come up one cycle past their limit.
          if (RX_EN_CYC <= 1)
          begin
            rx_state_ff  <= rfb_pkg::RFB_RX_ON;
            rx_active_ff <= 1'b1;
          end
          else
          begin
            rx_state_ff  <= rfb_pkg::RFB_RX_WAKE;
            rx_active_ff <= 1'b0;
          end
          wake_cnt_ff <= 8'h01;
        end
        rfb_pkg::RFB_RX_WAKE:
        begin
          if (wake_cnt_ff >= 8'(RX_EN_CYC - 1))
          begin
            rx_state_ff  <= rfb_pkg::RFB_RX_ON;
            rx_active_ff <= 1'b1;
          end
          else
          begin
            rx_state_ff  <= rfb_pkg::RFB_RX_WAKE;
            rx_active_ff <= 1'b0;
          end
          wake_cnt_ff <= wake_cnt_ff + 8'h01;
        end
        rfb_pkg::RFB_RX_ON:
        begin
          rx_state_ff  <= rfb_pkg::RFB_RX_ON;
          rx_active_ff <= 1'b1;
          wake_cnt_ff  <= wake_cnt_ff;
        end
        default:
        begin
          rx_state_ff  <= rfb_pkg::RFB_RX_OFF;
          rx_active_ff <= 1'b0;
          wake_cnt_ff  <= 8'h00;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------
  // Pin receivers and synchronisers
  // --------------------------------------------------------------------
  // Disabled receivers present zeros, so floating pins never reach the
  // filter or the register.
  always_comb
  begin
    raw_pins.clk_true = clk_true_in & rx_on;
    raw_pins.clk_comp = clk_comp_in & rx_on;
    raw_pins.data     = data_in & {DATA_W{rx_on}};
  end

  always_ff @(posedge clock_in or posedge sys_rst_in or posedge pin_rst)
  begin
    if (sys_rst_in || pin_rst)
    begin
      sync1_ff <= '0;
      sync2_ff <= '0;
      sync3_ff <= '0;
    end
    else
    begin
      sync1_ff <= raw_pins;
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
    end
  end

  // A pin change counts once the second and third stages agree.
  genvar gi;
  generate
    for (gi = 0; gi < DATA_W + 2; gi++)
    begin : g_filt
      assign nxt_lvl[gi] = (sync2_ff[gi] == sync3_ff[gi]) ? sync3_ff[gi] : lvl_ff[gi];
    end
  endgenerate

  always_ff @(posedge clock_in or posedge sys_rst_in or posedge pin_rst)
  begin
    if (sys_rst_in || pin_rst)
    begin
      lvl_ff       <= '0;
      cross_lvl_ff <= 1'b0;
    end
    else
    begin
      lvl_ff       <= nxt_lvl;
      cross_lvl_ff <= nxt_lvl.clk_true & ~nxt_lvl.clk_comp;
    end
  end

  // The crossing is true high with complement low, taken on its rising edge.
  assign cross_now = rx_on & nxt_lvl.clk_true & ~nxt_lvl.clk_comp & ~cross_lvl_ff;

  // --------------------------------------------------------------------
  // Data register and output banks
  // --------------------------------------------------------------------
  // Both banks are loaded from one filtered word, so they can never part.
  always_comb
  begin
    nxt_out_bank_a = out_bank_a_ff;
    nxt_out_bank_b = out_bank_b_ff;
    if (cross_now)
    begin
      nxt_out_bank_a = nxt_lvl.data;
      nxt_out_bank_b = nxt_lvl.data;
    end
  end

  always_ff @(posedge clock_in or posedge sys_rst_in or posedge pin_rst)
  begin
    if (sys_rst_in || pin_rst)
    begin
      out_bank_a_ff <= '0;
      out_bank_b_ff <= '0;
    end
    else
    begin
      out_bank_a_ff <= nxt_out_bank_a;
      out_bank_b_ff <= nxt_out_bank_b;
    end
  end

  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------
  chk_banks_equal: assert property (
    @(posedge clock_in) disable iff (sys_rst_in)
    out_bank_a_ff == out_bank_b_ff)
    else $error("Output banks differ.");

  chk_capture_data: assert property (
    @(posedge clock_in) disable iff (sys_rst_in)
    (cross_now && buf_rst_n_in) ##1 buf_rst_n_in |-> out_bank_a_ff == $past(nxt_lvl.data))
    else $error("Crossing did not capture the data.");

  chk_reset_low: assert property (
    @(posedge clock_in) disable iff (sys_rst_in)
    !buf_rst_n_in |-> (out_bank_a_ff == '0) && (out_bank_b_ff == '0))
    else $error("Outputs not low under pin reset.");

  chk_rx_off: assert property (
    @(posedge clock_in) disable iff (sys_rst_in)
    !buf_rst_n_in |-> !rx_active_out && (sync3_ff == '0))
    else $error("Receivers active during pin reset.");

  chk_no_early_capture: assert property (
    @(posedge clock_in) disable iff (sys_rst_in)
    (!rx_on && buf_rst_n_in) ##1 buf_rst_n_in |-> $stable(out_bank_a_ff))
    else $error("Outputs changed while receivers off.");

  chk_rx_wake: assert property (
    @(posedge clock_in) disable iff (sys_rst_in)
    $rose(buf_rst_n_in) |-> !rx_on ##[1:RX_EN_CYC] (rx_on || !buf_rst_n_in))
    else $error("Receiver wake-up out of bounds.");

  chk_hold_value: assert property (
    @(posedge clock_in) disable iff (sys_rst_in)
    (buf_rst_n_in && !cross_now) ##1 buf_rst_n_in |-> $stable(out_bank_a_ff))
    else $error("Outputs changed without a crossing.");

endmodule

// file: testbench/rfb_ctrl_model.sv
// Controller model: drives the reset, clock pair and data pins of the buffer.
// Assumes the bench calls its tasks just after a falling edge of clock_in.
`timescale 1ns/1ns
module rfb_ctrl_model
(
  input  wire logic        clock_in,
  output logic             rst_n_out,
  output logic             clk_true_out,
  output logic             clk_comp_out,
  output logic [12:0]      data_out
);
  initial
  begin
    rst_n_out = 1'b0;
    {clk_true_out, clk_comp_out, data_out} = {2'b01, 13'h0000};
  end
  // Each pin clock phase spans several core cycles, far below the rate ceiling.
  task automatic send(input logic [12:0] d);
    @(negedge clock_in) {clk_true_out, clk_comp_out, data_out} = {2'b01, d};
    repeat (4) @(negedge clock_in);
    {clk_true_out, clk_comp_out} = 2'b10;
    repeat (6) @(negedge clock_in);
    data_out = ~d;
  endtask
  // Moves the pins without a qualifying crossing.
  task automatic idle_noise(input logic [12:0] d);
    @(negedge clock_in) {clk_true_out, clk_comp_out, data_out} = {2'b11, d};
    repeat (4) @(negedge clock_in);
    {clk_true_out, clk_comp_out} = 2'b01;
    repeat (4) @(negedge clock_in);
  endtask
  // Floating pins are shown as levels that invert every cycle, crossings included.
  task automatic enter_reset;
    rst_n_out = 1'b0;
    repeat (2) @(negedge clock_in);
    repeat (6) @(negedge clock_in) {clk_true_out, clk_comp_out, data_out} =
      ~{clk_true_out, clk_comp_out, data_out};
  endtask
  task automatic leave_reset;
    @(negedge clock_in) {clk_true_out, clk_comp_out, data_out} = {2'b01, 13'h0000};
    repeat (2) @(negedge clock_in);
    rst_n_out = 1'b1;
    repeat (8) @(negedge clock_in);
  endtask
endmodule

// file: testbench/tb.sv
// Self-checking bench for the registered fanout buffer.
// Assumes the controller model drives every pin of the buffer except clock_in and sys_rst_in, which the bench drives.
`timescale 1ns/1ns
`include "rfb_cfg.svh"
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin miscompares++; \
  $display("unexpected t=%0t got %h exp %h", $time, a, b); end end
module tb;
  logic        clock_in;
  logic        sys_rst_in;
  logic        rst_n;
  logic        clk_t;
  logic        clk_c;
  logic        rx_act;
  logic [12:0] data;
  logic [12:0] bank_a;
  logic [12:0] bank_b;
  int          miscompares = 0;
  int          n_compared = 0;
  initial
  begin
    clock_in = 1'b0;
    forever #10 clock_in = ~clock_in;
  end
  rfb_ctrl_model rfb_ctrl_model_i (.clock_in(clock_in), .rst_n_out(rst_n),
    .clk_true_out(clk_t), .clk_comp_out(clk_c), .data_out(data));
  rfb_buffer rfb_buffer_i (.clock_in(clock_in), .sys_rst_in(sys_rst_in),
    .buf_rst_n_in(rst_n), .clk_true_in(clk_t), .clk_comp_in(clk_c), .data_in(data),
    .out_bank_a_out(bank_a), .out_bank_b_out(bank_b), .rx_active_out(rx_act));
  task automatic check_out(input logic [12:0] exp);
    `CHK(bank_a, exp)
    `CHK(bank_b, exp)
  endtask
  task automatic t_power_up;
    repeat (20) @(negedge clock_in);
    sys_rst_in = 1'b0;
    repeat (3) @(negedge clock_in);
    check_out(13'h0000);
    `CHK(rx_act, 1'b0)
    rfb_ctrl_model_i.leave_reset();
    `CHK(rx_act, 1'b1)
    check_out(13'h0000);
  endtask
  task automatic t_capture;
    logic [12:0] pat [6];
    pat = '{13'h1FFF, 13'h0000, 13'h1555, 13'h0AAA, 13'h0001, 13'h1000};
    foreach (pat[i])
    begin
      rfb_ctrl_model_i.send(pat[i]);
      check_out(pat[i]);
    end
  endtask
  task automatic t_hold;
    rfb_ctrl_model_i.idle_noise(13'h0F0F);
    check_out(13'h1000);
  endtask
  task automatic t_async_reset;
    rfb_ctrl_model_i.send(13'h0B3C);
    check_out(13'h0B3C);
    @(negedge clock_in);
    fork
      rfb_ctrl_model_i.enter_reset();
      begin
        #2 check_out(13'h0000);
      end
    join
    check_out(13'h0000);
    `CHK(rx_act, 1'b0)
    fork
      rfb_ctrl_model_i.leave_reset();
      begin
        @(posedge rst_n);
        #2 `CHK(rx_act, 1'b0)
        #(`RFB_RX_ENABLE_NS - 2) `CHK(rx_act, 1'b1)
      end
    join
    rfb_ctrl_model_i.send(13'h0C3A);
    check_out(13'h0C3A);
  endtask
  task automatic final_report;
    $display("compared %0d, miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    #200000;
    miscompares++;
    final_report();
  end
  initial
  begin
    sys_rst_in = 1'b1;
    t_power_up();
    t_capture();
    t_hold();
    t_async_reset();
    final_report();
  end
endmodule
